/* File: core/dram_power_state_manager.sv */
// per-rank power-down and self-refresh control for a ddr3 controller
`timescale 1ns/1ps
module dram_power_state_manager
    import dram_pwr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // firmware configuration
    input  wire logic                  cke_release,
    input  wire logic                  dyn_sr_enable,
    input  wire logic [TIMER_W-1:0]    pd_idle_threshold,
    input  wire logic [TIMER_W-1:0]    sr_idle_threshold,
    input  wire logic [PHY_MODE_W-1:0] phy_mode_sel,
    input  wire logic [REF_DIV_W-1:0]  refresh_divider,
    input  wire logic                  page_close_enable,
    // command queue status
    input  wire logic [NUM_RANKS-1:0]  rank_cmd_pending,
    input  wire logic [NUM_RANKS-1:0]  rank_cmd_issue,
    input  wire logic [NUM_RANKS-1:0]  rank_banks_open,
    input  wire logic                  cmd_queue_empty,
    input  wire logic                  cmd_arriving,
    input  wire logic [PRIO_W-1:0]     upstream_priority,
    input  wire logic                  refresh_due,
    input  wire logic                  cal_request,
    // power management unit
    input  wire logic                  suspend_msg,
    input  wire logic                  resume_msg,
    input  wire logic                  dram_reset_req_n,
    // memory side
    output logic [NUM_RANKS-1:0]       mem_clock_enable_out,
    output logic                       dram_reset_out_n,
    output logic                       mem_outputs_enable,
    // to command scheduler
    output logic                       refresh_issue,
    output logic [NUM_RANKS-1:0]       page_close_req,
    output logic                       cal_grant,
    // to physical layer
    output logic                       phy_pm_cmd_valid,
    output logic [PHY_MODE_W-1:0]      phy_pm_cmd_mode,
    // status
    output logic [1:0]                 rank_pd_state [NUM_RANKS],
    output logic                       self_refresh_active
);
    typedef struct packed {
        logic                        released;
        rank_state_t [NUM_RANKS-1:0] rank;
        sr_state_t                   sr;
        logic [3:0]                  calCnt;
        logic [REF_DIV_W-1:0]        refCnt;
        logic                        refIssue;
        logic [NUM_RANKS-1:0]        pageClose;
        logic                        pmValid;
        logic [PHY_MODE_W-1:0]       pmMode;
        logic [NUM_RANKS-1:0]        cke;
        logic                        rstN;
    } state_t;

    state_t stateFf;
    state_t nxtState;

    logic [NUM_RANKS-1:0] pdExpired;
    logic                 srExpired;
    logic                 anyCmd;

    assign anyCmd = |rank_cmd_issue | cmd_arriving | ~cmd_queue_empty;

    genvar g;
    generate
        for (g = 0; g < NUM_RANKS; g++) begin : g_rank
            rank_idle_timer u_pd_timer (
                .clk       (clk),
                .rst_n     (rst_n),
                .restart   (rank_cmd_issue[g] | rank_cmd_pending[g]),
                .threshold (pd_idle_threshold),
                .expired   (pdExpired[g])
            );
        end
    endgenerate

    rank_idle_timer u_sr_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .restart   (anyCmd),
        .threshold (sr_idle_threshold),
        .expired   (srExpired)
    );

    function automatic logic srEntryOk(input logic [NUM_RANKS-1:0] open,
                                       input logic qEmpty,
                                       input logic arriving,
                                       input logic [PRIO_W-1:0] prio,
                                       input logic expired);
        srEntryOk = (open == '0) && qEmpty && !arriving
                    && (prio < PRIO_SR_LIMIT) && expired;
    endfunction

    always_comb begin
        nxtState           = stateFf;
        nxtState.refIssue  = 1'b0;
        nxtState.pmValid   = 1'b0;
        nxtState.pageClose = '0;
        nxtState.rstN      = dram_reset_req_n;
        if (cke_release) begin
            nxtState.released = 1'b1;
        end

        // self-refresh control
        case (stateFf.sr)
            SR_OFF: begin
                if (suspend_msg) begin
                    nxtState.sr      = SR_SUSPEND;
                    nxtState.pmValid = 1'b1;
                    nxtState.pmMode  = phy_mode_sel;
                end else if (dyn_sr_enable && stateFf.released
                             && srEntryOk(rank_banks_open, cmd_queue_empty,
                                          cmd_arriving, upstream_priority,
                                          srExpired)) begin
                    nxtState.sr      = SR_DYN;
                    nxtState.pmValid = 1'b1;
                    nxtState.pmMode  = phy_mode_sel;
                end
            end
            SR_DYN: begin
                if (suspend_msg) begin
                    nxtState.sr = SR_SUSPEND;
                end else if (anyCmd || !dyn_sr_enable) begin
                    nxtState.sr = SR_OFF;
                end else if (cal_request) begin
                    nxtState.sr     = SR_CAL_EXIT;
                    nxtState.calCnt = CAL_EXIT_CNT;
                end
            end
            SR_CAL_EXIT: begin
                // memory is awake here, so suspend re-arms the phy
                if (suspend_msg) begin
                    nxtState.sr      = SR_SUSPEND;
                    nxtState.pmValid = 1'b1;
                    nxtState.pmMode  = phy_mode_sel;
                end else if (anyCmd || !dyn_sr_enable) begin
                    nxtState.sr = SR_OFF;
                end else if (stateFf.calCnt != '0) begin
                    nxtState.calCnt = stateFf.calCnt - 4'h1;
                end else begin
                    nxtState.sr = SR_CAL_HOLD;
                end
            end
            SR_CAL_HOLD: begin
                if (suspend_msg) begin
                    nxtState.sr = SR_SUSPEND;
                end else if (anyCmd || !dyn_sr_enable) begin
                    nxtState.sr = SR_OFF;
                end else if (!cal_request) begin
                    nxtState.sr = SR_DYN;
                end
            end
            SR_SUSPEND: begin
                if (resume_msg) begin
                    nxtState.sr = SR_OFF;
                end
            end
            default: nxtState.sr = SR_OFF;
        endcase

        // per-rank power-down
        for (int r = 0; r < NUM_RANKS; r++) begin
            case (stateFf.rank[r])
                RK_ACTIVE: begin
                    if (!rank_cmd_pending[r] && pdExpired[r]
                        && stateFf.released) begin
                        if (rank_banks_open[r]) begin
                            nxtState.rank[r] = RK_ACT_PD;
                            nxtState.pageClose[r] = page_close_enable;
                        end else begin
                            nxtState.rank[r] = RK_PRE_PD;
                        end
                    end
                end
                default: begin
                    if (rank_cmd_pending[r] || rank_cmd_issue[r]) begin
                        nxtState.rank[r] = RK_ACTIVE;
                    end
                end
            endcase
            // calibration exit needs cke high even on a powered-down rank
            nxtState.cke[r] = stateFf.released
                              && ((nxtState.rank[r] == RK_ACTIVE
                                   && nxtState.sr == SR_OFF)
                                  || nxtState.sr == SR_CAL_EXIT);
        end

        // thinned refresh: one refresh out per divider+1 due pulses
        if (refresh_due && stateFf.sr == SR_OFF) begin
            if (stateFf.refCnt >= refresh_divider) begin
                nxtState.refCnt   = '0;
                nxtState.refIssue = 1'b1;
            end else begin
                nxtState.refCnt = stateFf.refCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateFf      <= '0;
            stateFf.sr   <= SR_OFF;
            stateFf.rstN <= 1'b0;
            for (int r = 0; r < NUM_RANKS; r++) begin
                stateFf.rank[r] <= RK_ACTIVE;
            end
        end else begin
            stateFf <= nxtState;
        end
    end

    // outputs
    assign mem_clock_enable_out = stateFf.cke;
    assign dram_reset_out_n     = stateFf.rstN;
    // float everything but cke and reset while self-refreshing
    assign mem_outputs_enable   = stateFf.released
                                  && (stateFf.sr == SR_OFF
                                      || stateFf.sr == SR_CAL_EXIT);
    assign refresh_issue        = stateFf.refIssue;
    assign page_close_req       = stateFf.pageClose;
    assign cal_grant            = (stateFf.sr == SR_CAL_EXIT);
    assign phy_pm_cmd_valid     = stateFf.pmValid;
    assign phy_pm_cmd_mode      = stateFf.pmMode;
    assign self_refresh_active  = (stateFf.sr != SR_OFF)
                                  && (stateFf.sr != SR_CAL_EXIT);
    always_comb begin
        for (int r = 0; r < NUM_RANKS; r++) begin
            rank_pd_state[r] = stateFf.rank[r];
        end
    end
endmodule

/* File: core/dram_pwr_pkg.sv */
// constants and types shared by the dram power-state manager
package dram_pwr_pkg;
    localparam int          NUM_RANKS       = 2;
    localparam int          TIMER_W         = 16;
    localparam int          PRIO_W          = 3;
    localparam logic [2:0]  PRIO_SR_LIMIT   = 3'h2;
    localparam int          PHY_MODE_W      = 2;
    localparam int          REF_DIV_W       = 4;
    localparam logic [15:0] PD_IDLE_RST     = 16'h0040;
    localparam logic [15:0] SR_IDLE_RST     = 16'h0400;
    localparam logic [3:0]  REF_DIV_RST     = 4'h1;
    localparam int          RES_NS          = 10;
    localparam int          CLK_NS          = 5;
    localparam int          CAL_EXIT_CYC    = (RES_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  CAL_EXIT_CNT    = CAL_EXIT_CYC[3:0];

    typedef enum logic [1:0] {
        RK_ACTIVE,
        RK_ACT_PD,
        RK_PRE_PD
    } rank_state_t;

    typedef enum logic [2:0] {
        SR_OFF,
        SR_DYN,
        SR_SUSPEND,
        SR_CAL_EXIT,
        SR_CAL_HOLD
    } sr_state_t;
endpackage

/* File: core/rank_idle_timer.sv */
// idle down-counter with programmable threshold
`timescale 1ns/1ps
module rank_idle_timer
    import dram_pwr_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // control
    input  wire logic               restart,
    input  wire logic [TIMER_W-1:0] threshold,
    // status
    output logic                    expired
);
    typedef struct packed {
        logic [TIMER_W-1:0] cnt;
        logic               done;
    } tmr_t;

    tmr_t stateFf;
    tmr_t nxtState;

    always_comb begin
        nxtState = stateFf;
        if (restart) begin
            nxtState.cnt  = threshold;
            nxtState.done = 1'b0;
        end else if (stateFf.cnt != '0) begin
            nxtState.cnt = stateFf.cnt - 1'b1;
        end else begin
            nxtState.done = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign expired = stateFf.done;
endmodule

/* File: tb/dram_pwr_sva.sv */
// port assertions for the dram power-state manager
`timescale 1ns/1ps
module dram_pwr_sva
    import dram_pwr_pkg::*;
(
    // clock, reset and inputs
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cke_release,
    input wire logic       dyn_sr_enable,
    input wire logic [1:0] phy_mode_sel,
    input wire logic [1:0] rank_cmd_pending,
    input wire logic [1:0] rank_banks_open,
    input wire logic       cmd_queue_empty,
    input wire logic       cmd_arriving,
    input wire logic [2:0] upstream_priority,
    input wire logic       refresh_due,
    input wire logic       cal_request,
    input wire logic       suspend_msg,
    // outputs
    input wire logic [1:0] mem_clock_enable_out,
    input wire logic       mem_outputs_enable,
    input wire logic       refresh_issue,
    input wire logic       cal_grant,
    input wire logic       phy_pm_cmd_valid,
    input wire logic [1:0] phy_pm_cmd_mode,
    input wire logic [1:0] rank_pd_state [NUM_RANKS],
    input wire logic       self_refresh_active
);
    logic relFf;
    logic srOk;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) relFf <= rst_n & (relFf | cke_release);
    assign srOk = dyn_sr_enable & cmd_queue_empty & ~cmd_arriving
        & (rank_banks_open == 2'h0) & (upstream_priority < PRIO_SR_LIMIT);
    AST_CKE_HELD: assert property (
        !relFf |-> mem_clock_enable_out == 2'h0)
        else $error("clock enable raised before release");
    AST_SR_QUIET: assert property (
        self_refresh_active && !cal_grant |-> !mem_outputs_enable)
        else $error("outputs driven in self-refresh");
    AST_SUSPEND: assert property (
        relFf && suspend_msg && !self_refresh_active
        |=> self_refresh_active && phy_pm_cmd_valid
        && phy_pm_cmd_mode == $past(phy_mode_sel))
        else $error("suspend ignored");
    AST_PHY_PULSE: assert property (
        phy_pm_cmd_valid |=> !phy_pm_cmd_valid)
        else $error("phy command longer than a pulse");
    AST_PD_KIND: assert property (
        $fell(mem_clock_enable_out[0]) && !self_refresh_active
        |-> rank_pd_state[0] == ($past(rank_banks_open[0]) ? 2'h1 : 2'h2))
        else $error("wrong pd kind");
    AST_PD_IDLE: assert property (
        rank_pd_state[1] != 2'h0 && $past(rank_pd_state[1]) == 2'h0
        |-> !$past(rank_cmd_pending[1]))
        else $error("busy rank powered down");
    AST_DYN_SR: assert property (
        $rose(self_refresh_active) && !$past(suspend_msg) |-> $past(srOk))
        else $error("bad sr entry");
    AST_REFRESH: assert property (
        refresh_issue |-> $past(refresh_due) && !$past(self_refresh_active))
        else $error("refresh without cause");
    AST_CAL: assert property (
        $rose(cal_grant) |-> $past(cal_request) && $past(self_refresh_active))
        else $error("cal grant outside sr");
endmodule

bind dram_power_state_manager dram_pwr_sva dram_pwr_sva_inst (.*);

/* File: tb/ddr3_rank_model.sv */
// ddr3 ranks that flag command lines driven while asleep
`timescale 1ns/1ps
module ddr3_rank_model (
    // memory side pins
    input  wire logic       clk,
    input  wire logic [1:0] cke,
    input  wire logic       drv,
    input  wire logic       srAct,
    // verdict
    output logic            badDrive
);
    initial badDrive = 1'b0;
    // sleeping ranks ignore cke-only traffic, anything else is a fault
    always @(posedge clk) begin
        if (srAct && cke == 2'h0 && drv) begin
            badDrive <= 1'b1;
        end
    end
endmodule

/* File: tb/dram_power_state_manager_tb.sv */
// self-checking bench for the dram power-state manager
`timescale 1ns/1ps
module dram_power_state_manager_tb
    import dram_pwr_pkg::*;
;
    logic clk, rst_n, cke_release, dyn_sr_enable, page_close_enable;
    logic [TIMER_W-1:0] pd_idle_threshold, sr_idle_threshold;
    logic [1:0] phy_mode_sel, phy_pm_cmd_mode, rank_cmd_pending;
    logic [1:0] rank_cmd_issue, rank_banks_open, mem_clock_enable_out;
    logic [1:0] page_close_req, rank_pd_state [NUM_RANKS];
    logic [3:0] refresh_divider;
    logic [2:0] upstream_priority;
    logic cmd_queue_empty, cmd_arriving, refresh_due, cal_request;
    logic suspend_msg, resume_msg, dram_reset_req_n, dram_reset_out_n;
    logic mem_outputs_enable, refresh_issue, cal_grant, phy_pm_cmd_valid;
    logic self_refresh_active, badDrive;
    int n_fail, num_checks, i, k, thr, d, nRef, nPc, nCke;
    dram_power_state_manager dram_power_state_manager_inst (.*);
    ddr3_rank_model ddr3_rank_model_inst (.clk(clk),
        .cke(mem_clock_enable_out), .drv(mem_outputs_enable),
        .srAct(self_refresh_active), .badDrive(badDrive));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        nRef += refresh_issue;
        nPc += page_close_req[0];
        nCke += mem_clock_enable_out[0];
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
    initial begin
        i = $urandom(64657);
        {rst_n, cke_release, dyn_sr_enable, refresh_divider} = '0;
        {phy_mode_sel, rank_cmd_issue, cmd_queue_empty, cmd_arriving} = '0;
        {upstream_priority, refresh_due, cal_request, suspend_msg} = '0;
        {resume_msg, rank_cmd_pending, page_close_enable} = '0;
        {dram_reset_req_n, rank_banks_open} = 3'h5;
        pd_idle_threshold = 16'h0006;
        sr_idle_threshold = 16'h0008;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk(mem_clock_enable_out, 2'h0);
        chk(rank_pd_state[0], 2'h0);
        @(posedge clk) {cke_release, rank_cmd_pending, page_close_enable} <= 4'hF;
        @(posedge clk) cke_release <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(mem_clock_enable_out, 2'h3);
        thr = 4 + $urandom % 8;
        @(posedge clk) pd_idle_threshold <= thr[15:0];
        @(posedge clk) {nPc, rank_cmd_pending} <= 2'h2;
        repeat (thr / 2) @(posedge clk);
        rank_cmd_pending <= 2'h0;
        // rank 1 kept busy longer, so the ranks must sleep apart
        i = thr / 2;
        while (rank_pd_state[0] === 2'h0 && i < 4 * thr) begin
            @(posedge clk);
            #1 i++;
        end
        chk(i >= thr + 1 && i <= thr + 5, 1'b1);
        chk(rank_pd_state[0], 2'h1);
        chk(rank_pd_state[1], 2'h0);
        chk(mem_clock_enable_out, 2'h2);
        for (i = 0; rank_pd_state[1] === 2'h0 && i < 4 * thr; i++)
            #5;
        chk(rank_pd_state[1], 2'h2);
        chk(nPc > 0, 1'b1);
        @(posedge clk) {dyn_sr_enable, cmd_queue_empty, rank_banks_open} <= 4'hC;
        upstream_priority <= PRIO_SR_LIMIT;
        repeat (40) @(posedge clk);
        #1 chk(self_refresh_active, 1'b0);
        @(posedge clk) upstream_priority <= 3'($urandom % 2);
        #1;
        for (i = 0; self_refresh_active !== 1'b1 && i < 40; i++)
            #5;
        chk(self_refresh_active, 1'b1);
        chk(mem_outputs_enable, 1'b0);
        @(posedge clk) {nCke, cal_request} <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(nCke, CAL_EXIT_CYC + 1);
        @(posedge clk) cal_request <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({self_refresh_active, cal_grant}, 2'h2);
        for (k = 1; k >= 0; k--) begin
            @(posedge clk) cmd_arriving <= k[0];
            #1;
            for (i = 0; self_refresh_active !== !k[0] && i < 40; i++)
                #5;
            chk(self_refresh_active, !k[0]);
        end
        // issued then pending commands must wake both sleeping ranks
        @(posedge clk) {dyn_sr_enable, rank_cmd_issue} <= 3'h3;
        @(posedge clk) {rank_cmd_issue, rank_cmd_pending} <= 4'h3;
        repeat (3) @(posedge clk);
        #1 chk(mem_clock_enable_out, 2'h3);
        @(posedge clk) {suspend_msg, cmd_arriving} <= 2'h3;
        phy_mode_sel <= 2'($urandom);
        @(posedge clk) suspend_msg <= 1'b0;
        #1 chk({phy_pm_cmd_valid, phy_pm_cmd_mode}, {1'b1, phy_mode_sel});
        chk(self_refresh_active, 1'b1);
        repeat (20) @(posedge clk);
        #1 chk({self_refresh_active, mem_outputs_enable}, 2'h2);
        @(posedge clk) resume_msg <= 1'b1;
        @(posedge clk) {resume_msg, cmd_arriving} <= 2'h0;
        d = $urandom % 4;
        refresh_divider <= d[3:0];
        repeat (4) @(posedge clk);
        nRef = 0;
        for (k = 0; k < 4 * (d + 1); k++) begin
            @(posedge clk) refresh_due <= 1'b1;
            @(posedge clk) refresh_due <= 1'b0;
        end
        repeat (4) @(posedge clk);
        #1 chk(nRef, 4);
        @(posedge clk) dram_reset_req_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(dram_reset_out_n, 1'b0);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(mem_clock_enable_out, 2'h0);
        chk(badDrive, 1'b0);
        finish_test;
    end
endmodule
